// *** tb_wpc_pin_cfg.sv ***
// self-checking bench for the waveform port pin block with a reference model
`default_nettype none
module tb_wpc_pin_cfg;
  timeunit 1ns;
  timeprecision 100ps;
  // design inputs, all valued at time zero
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, usb_byte = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic addr_inc = 1'b0, lane_drive = 1'b0, word_ready = 1'b0, usb_valid = 1'b0, run = 1'b0;
  logic [2:0] engine_state = 3'h0;
  // design outputs
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, word_valid, usb_ready;
  logic [1:0] s_bresp, s_rresp, r;
  logic [31:0] s_rdata, d;
  logic [15:0] word_data, periph_addr;
  logic [8:0] engine_address_out, engine_address_oe_n, v;
  logic [2:0] debug_state_out, debug_state_oe_n;
  wpc_pkg::wpc_lane_t low_lane_port, high_lane_port;
  logic interface_clock_in, interface_clock_out, interface_clock_oe_n, interface_clock_edge;
  // bench state and reference model of the byte pairing
  int n_fail = 0, compares = 0, seed = 40468, n_edge = 0, n_rise, e0, r0, i, wide = 1, hold = 0;
  int n_out = 0, o0;
  logic go = 1'b0, out_q = 1'b0;
  logic [7:0] held;
  logic [15:0] wq[$];

  wpc_pin_cfg #(.WORD_W(16)) wpc_pin_cfg_inst (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .addr_inc,
    .engine_state, .lane_drive, .word_ready, .word_data, .word_valid, .usb_byte, .usb_valid,
    .usb_ready, .engine_address_out, .engine_address_oe_n, .debug_state_out,
    .debug_state_oe_n, .low_lane_port, .high_lane_port, .interface_clock_in,
    .interface_clock_out, .interface_clock_oe_n, .interface_clock_edge);
  wpc_peer wpc_peer_inst (.run, .hi_bits(low_lane_port.out[6:0]), .addr_pins(engine_address_out),
    .addr_oe_n(engine_address_oe_n), .ext_clk(interface_clock_in), .n_rise, .periph_addr);

  // 125 MHz clock
  always #4 aclk = ~aclk;
  // edge pulses of the selected interface clock
  // and rises of the driven clock pin, which must run at the same rate
  always @(posedge aclk) begin
    if (interface_clock_edge === 1'b1) n_edge++;
    if (interface_clock_out === 1'b1 && out_q === 1'b0) n_out++;
    out_q <= interface_clock_out;
  end
  // random drain stalls, and every popped word compared with the model
  always @(posedge aclk) begin
    word_ready <= go & 1'($random(seed));
    if (aresetn && word_valid === 1'b1 && word_ready) chk(32'(word_data), 32'(wq.pop_front()));
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // axi4-lite write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] resp);
    // one idle edge first, so no ready line is lowered and raised in one time step
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= w;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && s_bready) begin
        resp = s_bresp;
        s_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] resp);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) begin
        q = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
        break;
      end
    end
  endtask
  // one usb byte into the buffer; the model pairs bytes first-low in wide mode
  task automatic put(input logic [7:0] b);
    usb_byte <= b;
    usb_valid <= 1'b1;
    // usb_ready high ends this wait; if it never rises, the watchdog does
    do @(posedge aclk); while (usb_ready !== 1'b1);
    usb_valid <= 1'b0;
    if (wide == 0) wq.push_back({8'h00, b});
    else if (hold == 1) wq.push_back({b, held});
    else held = b;
    hold = (wide != 0) && (hold == 0);
    @(posedge aclk);
  endtask
  task automatic drain();
    go <= 1'b1;
    while (wq.size() != 0) @(posedge aclk);
    go <= 1'b0;
    cyc(4);
    chk(32'(word_valid), 32'h0);
  endtask
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #160000;
    n_fail++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, d, r);
    chk(d, 32'hc0);
    chk(32'({interface_clock_oe_n, debug_state_oe_n}), 32'hf);
    chk(32'(engine_address_oe_n), 32'h1ff);
    rd(8'h1c, d, r);
    chk({d[29:0], r}, 32'h2);
    wr(8'h1c, 32'h0, r);
    chk(32'(r), 32'h2);
    // port mode: lanes follow general i/o
    wr(8'h10, 32'h5aa5, r);
    wr(8'h14, 32'hffff, r);
    cyc(3);
    chk({low_lane_port, high_lane_port}, 32'ha5005a00);
    // address preset, increment and wrap
    v = 9'($random(seed));
    wr(8'h08, 32'h1ff, r);
    wr(8'h04, 32'(v), r);
    cyc(2);
    chk(32'({engine_address_oe_n, engine_address_out}), 32'(v));
    chk(32'(periph_addr), {16'h0, 7'h25, v});
    wr(8'h04, 32'h1fe, r);
    addr_inc <= 1'b1;
    cyc(2);
    addr_inc <= 1'b0;
    cyc(3);
    chk(32'(engine_address_out), 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(8'h08, i ? 32'h1ff0000 : 32'h1ff, r);
      cyc(3);
      chk(32'(engine_address_oe_n), 32'h0);
      wr(8'h08, 32'h0, r);
      cyc(3);
      chk(32'(engine_address_oe_n), 32'h1ff);
    end
    // debug state pins
    wr(8'h00, 32'hc4, r);
    for (i = 0; i < 4; i++) begin
      engine_state <= 3'($random(seed));
      cyc(3);
      chk(32'({debug_state_oe_n, debug_state_out}), 32'(engine_state));
    end
    wr(8'h00, 32'hc0, r);
    cyc(3);
    chk(32'(debug_state_oe_n), 32'h7);
    // master mode, wide: fill until refused, check lanes, drain with stalls
    wr(8'h00, 32'hc2, r);
    lane_drive <= 1'b1;
    for (i = 0; i < 4; i++) put(8'($random(seed)));
    cyc(3);
    chk(32'(usb_ready), 32'h0);
    chk({low_lane_port, high_lane_port}, {wq[0][7:0], 8'h00, wq[0][15:8], 8'h00});
    drain();
    wr(8'h0c, 32'h0, r);
    wide = 0;
    // three words overflow two entries, so the drain runs while filling
    go <= 1'b1;
    for (i = 0; i < 3; i++) put(8'($random(seed)));
    drain();
    chk(32'(high_lane_port), 32'h5a00);
    // internal clock rates over 120 cycles
    for (i = 0; i < 2; i++) begin
      wr(8'h00, i ? 32'h80 : 32'hc0, r);
      e0 = n_edge;
      o0 = n_out;
      cyc(120);
      chk(32'((n_edge - e0) inside {[29 - 10 * i : 31 - 10 * i]}), 32'h1);
      chk(32'((n_out - o0) inside {[29 - 10 * i : 31 - 10 * i]}), 32'h1);
    end
    wr(8'h00, 32'ha0, r);
    cyc(3);
    chk(32'(interface_clock_oe_n), 32'h0);
    wr(8'h00, 32'h20, r);
    cyc(3);
    chk(32'(interface_clock_oe_n), 32'h1);
    // external clock burst, edges counted on both sides
    e0 = n_edge;
    r0 = n_rise;
    run <= 1'b1;
    cyc(125);
    run <= 1'b0;
    cyc(20);
    chk(32'(n_edge - e0), 32'(n_rise - r0));
    for (i = 0; i < 2; i++) begin
      wr(8'h00, i ? 32'h20 : 32'h30, r);
      cyc(8);
      rd(8'h18, d, r);
      chk(32'(d[3]), 32'(1 - i));
    end
    summarize();
  end
endmodule
`default_nettype wire

// *** wpc_cfg.svh ***
// offsets, field positions, reset values and timing counts of the waveform port pin block
`ifndef WPC_CFG_SVH
`define WPC_CFG_SVH
// register byte offsets
`define WPC_OFS_SETUP     8'h00
`define WPC_OFS_ADDR      8'h04
`define WPC_OFS_ADDR_PINS 8'h08
`define WPC_OFS_FIFO      8'h0c
`define WPC_OFS_GPIO_OUT  8'h10
`define WPC_OFS_GPIO_OE   8'h14
`define WPC_OFS_STATUS    8'h18
// reset values
`define WPC_RST_SETUP     8'hc0
`define WPC_RST_WIDE      4'hf
// field positions
`define WPC_ADDR_OE_LSB   16
`define WPC_DBG_ALT_LSB   16
`define WPC_MODE_MASTER   2'b10
// axi responses
`define WPC_RESP_OKAY     2'b00
`define WPC_RESP_SLVERR   2'b10
// clock rates in MHz and half-period counts of the internal interface clock
`define WPC_CLK_MHZ       125
`define WPC_INT_FAST_MHZ  48
`define WPC_INT_SLOW_MHZ  30
`define WPC_HALF_FAST     ((`WPC_CLK_MHZ + 2 * `WPC_INT_FAST_MHZ - 1) / (2 * `WPC_INT_FAST_MHZ))
`define WPC_HALF_SLOW     ((`WPC_CLK_MHZ + 2 * `WPC_INT_SLOW_MHZ - 1) / (2 * `WPC_INT_SLOW_MHZ))
`endif

// *** wpc_peer.sv ***
// far-side peripheral: external interface clock source and address decode
`default_nettype none
module wpc_peer (
  // control from the bench
  input  wire logic       run,
  input  wire logic [6:0] hi_bits,
  // pins of the block
  input  wire logic [8:0] addr_pins,
  input  wire logic [8:0] addr_oe_n,
  output logic            ext_clk,
  output int              n_rise,
  output logic [15:0]     periph_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] last_addr = 9'h000;
  // 8 MHz, inside the 5..48 MHz band; parked low between bursts
  initial ext_clk = 1'b0;
  always begin
    #62.5;
    ext_clk = run ? ~ext_clk : 1'b0;
  end
  // rising edges seen by the peripheral, for the bench to compare
  initial n_rise = 0;
  always @(posedge ext_clk) n_rise++;
  // no pull on the address lines: a floating line shows the inverse of its last value
  always @(addr_pins or addr_oe_n) if (addr_oe_n == 9'h000) last_addr = addr_pins;
  // engine address on the low bits, general i/o above it
  assign periph_addr = {hi_bits, (addr_oe_n == 9'h000) ? addr_pins : ~last_addr};
endmodule
`default_nettype wire

// *** wpc_pin_cfg.sv ***
// pin steering, address output and interface clock control of the waveform port
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`include "wpc_cfg.svh"
`default_nettype none
module wpc_pin_cfg #(
  parameter int WORD_W = 16
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite slave
  input  wire logic [7:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [7:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // waveform engine side, same clock
  input  wire logic              addr_inc,
  input  wire logic [2:0]        engine_state,
  input  wire logic              lane_drive,
  input  wire logic              word_ready,
  output logic [WORD_W-1:0]      word_data,
  output logic                   word_valid,
  // usb byte stream in
  input  wire logic [7:0]        usb_byte,
  input  wire logic              usb_valid,
  output logic                   usb_ready,
  // pins
  output logic [8:0]             engine_address_out,
  output logic [8:0]             engine_address_oe_n,
  output logic [2:0]             debug_state_out,
  output logic [2:0]             debug_state_oe_n,
  output wpc_pkg::wpc_lane_t     low_lane_port,
  output wpc_pkg::wpc_lane_t     high_lane_port,
  input  wire logic              interface_clock_in,
  output logic                   interface_clock_out,
  output logic                   interface_clock_oe_n,
  output logic                   interface_clock_edge
);

  // byte-lane merge of a write, used for every register but the read-only status word
  function automatic logic [31:0] wpc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // register state
  wpc_pkg::wpc_setup_t setup_ff;
  logic [8:0]          addr_cnt_ff;
  logic [8:0]          addr_alt_ff;
  logic [8:0]          addr_oe_ff;
  logic [3:0]          wide_ff;
  logic [15:0]         gpio_out_ff;
  logic [2:0]          dbg_alt_ff;
  logic [15:0]         gpio_oe_ff;

  // axi state
  logic              aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
  logic [7:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic              arready_ff, rvalid_ff;
  logic [31:0]       rdata_ff;

  // axi decode; address and data may arrive in either order
  wire aw_take = s_awvalid & awready_ff;
  wire w_take  = s_wvalid & wready_ff;
  wire do_wr   = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire ar_take = s_arvalid & arready_ff;
  wire nxt_aw_full = (aw_full_ff | aw_take) & ~do_wr;
  wire nxt_w_full  = (w_full_ff | w_take) & ~do_wr;
  wire nxt_bvalid  = (bvalid_ff & ~s_bready) | do_wr;
  wire nxt_rvalid  = (rvalid_ff & ~s_rready) | ar_take;
  wire wr_setup = do_wr & (awaddr_ff == `WPC_OFS_SETUP);
  wire wr_addr  = do_wr & (awaddr_ff == `WPC_OFS_ADDR);
  wire wr_pins  = do_wr & (awaddr_ff == `WPC_OFS_ADDR_PINS);
  wire wr_fifo  = do_wr & (awaddr_ff == `WPC_OFS_FIFO);
  wire wr_gout  = do_wr & (awaddr_ff == `WPC_OFS_GPIO_OUT);
  wire wr_goe   = do_wr & (awaddr_ff == `WPC_OFS_GPIO_OE);
  wire wr_hit   = wr_setup | wr_addr | wr_pins | wr_fifo | wr_gout | wr_goe;

  wire [31:0] pins_word = {7'h00, addr_oe_ff, 7'h00, addr_alt_ff};
  wire [31:0] gout_word = {13'h0000, dbg_alt_ff, gpio_out_ff};
  wire [31:0] wr_val_setup = wpc_merge({24'h000000, setup_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_val_addr  = wpc_merge({23'h000000, addr_cnt_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_val_pins  = wpc_merge(pins_word, wdata_ff, wstrb_ff);
  wire [31:0] wr_val_fifo  = wpc_merge({28'h0000000, wide_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_val_gout  = wpc_merge(gout_word, wdata_ff, wstrb_ff);
  wire [31:0] wr_val_goe   = wpc_merge({16'h0000, gpio_oe_ff}, wdata_ff, wstrb_ff);

  // steering terms
  wire is_master = (setup_ff.mode == wpc_pkg::WPC_MASTER);
  wire is_wide   = |wide_ff;
  // selected interface clock level, also read back through the status word
  logic sel_lvl;

  // two-entry buffer: head is the output flop, spare absorbs a stall
  logic [WORD_W-1:0] head_ff, spare_ff;
  logic              head_v_ff, spare_v_ff, have_ff, ready_ff;
  logic [7:0]        hold_ff;
  wire accept   = usb_valid & ready_ff;
  wire push     = accept & (~is_wide | have_ff);
  wire [WORD_W-1:0] push_word = is_wide ? WORD_W'({usb_byte, hold_ff})
                                        : WORD_W'(usb_byte);
  wire pop      = head_v_ff & word_ready;
  wire head_free = ~head_v_ff | pop;
  wire nxt_head_v  = spare_v_ff | push | (head_v_ff & ~pop);
  wire nxt_spare_v = (spare_v_ff & ~head_free) | (push & ~head_free) |
                     (push & spare_v_ff & head_free);
  wire [WORD_W-1:0] nxt_head = ~head_free ? head_ff : (spare_v_ff ? spare_ff : push_word);
  wire [WORD_W-1:0] nxt_spare = (push & (spare_v_ff | ~head_free)) ? push_word : spare_ff;
  wire nxt_ready = ~(nxt_head_v & nxt_spare_v);
  wire nxt_have  = accept ? (is_wide & ~have_ff) : (have_ff & is_wide);

  // read mux; unmapped reads return zero with slverr
  wire [31:0] status_word = {24'h000000, spare_v_ff, head_v_ff, is_wide, is_master,
                             sel_lvl, engine_state};
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_araddr)
      `WPC_OFS_SETUP:     rd_mux = {24'h000000, setup_ff};
      `WPC_OFS_ADDR:      rd_mux = {23'h000000, addr_cnt_ff};
      `WPC_OFS_ADDR_PINS: rd_mux = pins_word;
      `WPC_OFS_FIFO:      rd_mux = {28'h0000000, wide_ff};
      `WPC_OFS_GPIO_OUT:  rd_mux = gout_word;
      `WPC_OFS_GPIO_OE:   rd_mux = {16'h0000, gpio_oe_ff};
      `WPC_OFS_STATUS:    rd_mux = status_word;
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // axi handshake registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `WPC_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `WPC_RESP_OKAY;
      rdata_ff   <= 32'h00000000;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
    end else if (ce) begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff  <= nxt_w_full;
      awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_full & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (aw_take) awaddr_ff <= s_awaddr;
      if (w_take) begin
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      if (do_wr) bresp_ff <= wr_hit ? `WPC_RESP_OKAY : `WPC_RESP_SLVERR;
      if (ar_take) begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? `WPC_RESP_OKAY : `WPC_RESP_SLVERR;
      end
    end
  end

  // software registers; a preset write beats an increment in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_ff    <= wpc_pkg::wpc_setup_t'(`WPC_RST_SETUP);
      addr_cnt_ff <= 9'h000;
      addr_alt_ff <= 9'h000;
      addr_oe_ff  <= 9'h000;
      wide_ff     <= `WPC_RST_WIDE;
      gpio_out_ff <= 16'h0000;
      dbg_alt_ff  <= 3'h0;
      gpio_oe_ff  <= 16'h0000;
    end else if (ce) begin
      if (wr_setup) setup_ff <= wpc_pkg::wpc_setup_t'(wr_val_setup[7:0]);
      if (wr_addr) addr_cnt_ff <= wr_val_addr[8:0];
      else if (addr_inc) addr_cnt_ff <= addr_cnt_ff + 9'h001;
      if (wr_pins) begin
        addr_alt_ff <= wr_val_pins[8:0];
        addr_oe_ff  <= wr_val_pins[`WPC_ADDR_OE_LSB +: 9];
      end
      if (wr_fifo) wide_ff <= wr_val_fifo[3:0];
      if (wr_gout) begin
        gpio_out_ff <= wr_val_gout[15:0];
        dbg_alt_ff  <= wr_val_gout[`WPC_DBG_ALT_LSB +: 3];
      end
      if (wr_goe) gpio_oe_ff <= wr_val_goe[15:0];
    end
  end

  // buffer and byte pairing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      head_ff    <= '0;
      spare_ff   <= '0;
      head_v_ff  <= 1'b0;
      spare_v_ff <= 1'b0;
      have_ff    <= 1'b0;
      hold_ff    <= 8'h00;
      ready_ff   <= 1'b0;
    end else if (ce) begin
      head_ff    <= nxt_head;
      spare_ff   <= nxt_spare;
      head_v_ff  <= nxt_head_v;
      spare_v_ff <= nxt_spare_v;
      have_ff    <= nxt_have;
      ready_ff   <= nxt_ready;
      if (accept & ~have_ff) hold_ff <= usb_byte;
    end
  end

  // interface clock: external pin through three flops and a filter flop, internal by divider
  logic       ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_lvl_ff;
  logic [3:0] div_cnt_ff;
  logic       int_clk_ff, sel_prev_ff;
  wire [3:0] half_cnt = setup_ff.fast ? 4'(`WPC_HALF_FAST) : 4'(`WPC_HALF_SLOW);
  wire div_wrap = (div_cnt_ff >= half_cnt - 4'h1);
  wire nxt_int_clk = div_wrap ? ~int_clk_ff : int_clk_ff;
  // external frequency is assumed within 5..48 MHz, so each level spans at least one sample
  wire raw_clk  = setup_ff.clk_int ? int_clk_ff : ext_lvl_ff;
  assign sel_lvl = raw_clk ^ setup_ff.invert;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_ff   <= 1'b0;
      ext_s2_ff   <= 1'b0;
      ext_s3_ff   <= 1'b0;
      ext_lvl_ff  <= 1'b0;
      div_cnt_ff  <= 4'h0;
      int_clk_ff  <= 1'b0;
      sel_prev_ff <= 1'b0;
    end else if (ce) begin
      ext_s1_ff   <= interface_clock_in;
      ext_s2_ff   <= ext_s1_ff;
      ext_s3_ff   <= ext_s2_ff;
      if (ext_s2_ff == ext_s3_ff) ext_lvl_ff <= ext_s3_ff;
      div_cnt_ff  <= div_wrap ? 4'h0 : div_cnt_ff + 4'h1;
      int_clk_ff  <= nxt_int_clk;
      sel_prev_ff <= sel_lvl;
    end
  end

  // next pin values; every pin output is a flop
  wire [8:0] nxt_adr_oe_n = ~(addr_alt_ff | addr_oe_ff);
  wire [2:0] nxt_dbg_oe_n = setup_ff.dbg_sel ? 3'h0 : 3'h7;
  wire [2:0] nxt_dbg_out  = setup_ff.dbg_sel ? engine_state : 3'h0;
  wire       lane_on      = is_master & lane_drive;
  wire wpc_pkg::wpc_lane_t nxt_low  = is_master ?
      wpc_pkg::wpc_lane_t'{out: head_ff[7:0], oe_n: {8{~lane_on}}} :
      wpc_pkg::wpc_lane_t'{out: gpio_out_ff[7:0], oe_n: ~gpio_oe_ff[7:0]};
  wire wpc_pkg::wpc_lane_t nxt_high = (is_master & is_wide) ?
      wpc_pkg::wpc_lane_t'{out: head_ff[WORD_W-1:8], oe_n: {8{~lane_on}}} :
      wpc_pkg::wpc_lane_t'{out: gpio_out_ff[15:8], oe_n: ~gpio_oe_ff[15:8]};
  // only the internal source may be driven out; external keeps the pin an input
  wire nxt_clk_oe_n = ~(setup_ff.clk_int & setup_ff.clk_out_en);

  logic [8:0]         adr_out_ff, adr_oe_n_ff;
  logic [2:0]         dbg_out_ff, dbg_oe_n_ff;
  wpc_pkg::wpc_lane_t low_ff, high_ff;
  logic               clk_out_ff, clk_oe_n_ff, edge_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adr_out_ff  <= 9'h000;
      adr_oe_n_ff <= 9'h1ff;
      dbg_out_ff  <= 3'h0;
      dbg_oe_n_ff <= 3'h7;
      low_ff      <= '{out: 8'h00, oe_n: 8'hff};
      high_ff     <= '{out: 8'h00, oe_n: 8'hff};
      clk_out_ff  <= 1'b0;
      clk_oe_n_ff <= 1'b1;
      edge_ff     <= 1'b0;
    end else if (ce) begin
      adr_out_ff  <= addr_cnt_ff;
      adr_oe_n_ff <= nxt_adr_oe_n;
      dbg_out_ff  <= nxt_dbg_out;
      dbg_oe_n_ff <= nxt_dbg_oe_n;
      low_ff      <= nxt_low;
      high_ff     <= nxt_high;
      clk_out_ff  <= nxt_int_clk ^ setup_ff.invert;
      clk_oe_n_ff <= nxt_clk_oe_n;
      edge_ff     <= sel_lvl & ~sel_prev_ff;
    end
  end

  // output connections
  assign s_awready = awready_ff;
  assign s_wready  = wready_ff;
  assign s_bvalid  = bvalid_ff;
  assign s_bresp   = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid  = rvalid_ff;
  assign s_rdata   = rdata_ff;
  assign s_rresp   = rresp_ff;
  assign word_data = head_ff;
  assign word_valid = head_v_ff;
  assign usb_ready = ready_ff;
  assign engine_address_out   = adr_out_ff;
  assign engine_address_oe_n  = adr_oe_n_ff;
  assign debug_state_out      = dbg_out_ff;
  assign debug_state_oe_n     = dbg_oe_n_ff;
  assign low_lane_port        = low_ff;
  assign high_lane_port       = high_ff;
  assign interface_clock_out  = clk_out_ff;
  assign interface_clock_oe_n = clk_oe_n_ff;
  assign interface_clock_edge = edge_ff;

  // checks
  sequence s_preset;
    wr_addr && wstrb_ff[0] && wstrb_ff[1];
  endsequence
  // first byte, one idle cycle, second byte: the bench's byte pacing
  sequence s_pair;
    accept && is_wide && !have_ff ##1 !accept && is_wide ##1 accept && is_wide;
  endsequence
  property p_preset;
    @(posedge aclk) disable iff (!aresetn || !ce)
      s_preset ##1 ce |=> engine_address_out == $past(wdata_ff[8:0], 2);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not on address pins");
  property p_inc;
    @(posedge aclk) disable iff (!aresetn || !ce)
      addr_inc && !wr_addr |=> addr_cnt_ff == 9'($past(addr_cnt_ff) + 9'h001);
  endproperty
  a_inc: assert property (p_inc) else $error("address did not step");
  property p_hiz;
    @(posedge aclk) disable iff (!aresetn || !ce)
      (addr_alt_ff[0] == 1'b0 && addr_oe_ff[0] == 1'b0)[*2] |-> engine_address_oe_n[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("address pin driven while released");
  property p_dbg;
    @(posedge aclk) disable iff (!aresetn || !ce)
      setup_ff.dbg_sel ##1 ce |-> debug_state_oe_n == 3'h0 &&
                                 debug_state_out == $past(engine_state);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug pins wrong");
  property p_low;
    @(posedge aclk) disable iff (!aresetn || !ce)
      is_master && lane_drive ##1 ce |-> low_lane_port.oe_n == 8'h00 &&
                                        low_lane_port.out == $past(head_ff[7:0]);
  endproperty
  a_low: assert property (p_low) else $error("low lane not steered");
  property p_high;
    @(posedge aclk) disable iff (!aresetn || !ce)
      !is_wide ##1 ce |-> high_lane_port.out == $past(gpio_out_ff[15:8]);
  endproperty
  a_high: assert property (p_high) else $error("high lane taken while narrow");
  property p_pair;
    @(posedge aclk) disable iff (!aresetn || !ce)
      s_pair |-> push_word[15:8] == usb_byte && push_word[7:0] == $past(usb_byte, 2);
  endproperty
  a_pair: assert property (p_pair) else $error("byte pair order wrong");
  property p_clk_oe;
    @(posedge aclk) disable iff (!aresetn || !ce)
      !setup_ff.clk_int ##1 ce |-> interface_clock_oe_n;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock driven on external");
  property p_src;
    @(posedge aclk) disable iff (!aresetn || !ce)
      !setup_ff.clk_int && !setup_ff.invert && $rose(ext_lvl_ff) && $stable(setup_ff)
        |=> interface_clock_edge;
  endproperty
  a_src: assert property (p_src) else $error("external rise not seen");
  property p_reset;
    @(posedge aclk) !aresetn |=> setup_ff == wpc_pkg::wpc_setup_t'(`WPC_RST_SETUP) &&
                                 !is_master;
  endproperty
  a_reset: assert property (p_reset) else $error("bad setup after reset");
endmodule
`default_nettype wire

// *** wpc_pkg.sv ***
// types shared by the waveform port pin block
`default_nettype none
package wpc_pkg;
  typedef enum logic [1:0] {
    WPC_PORTS  = 2'b00,
    WPC_RSVD   = 2'b01,
    WPC_MASTER = 2'b10,
    WPC_SLAVE  = 2'b11
  } wpc_mode_t;

  // interface setup register layout, msb first
  typedef struct packed {
    logic      clk_int;
    logic      fast;
    logic      clk_out_en;
    logic      invert;
    logic      rsvd3;
    logic      dbg_sel;
    wpc_mode_t mode;
  } wpc_setup_t;

  // one byte-wide pin group: value and active-low enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } wpc_lane_t;
endpackage
`default_nettype wire
